// ==== dv/gp_pad_model.sv ====
// Pad and external driver model for one eight-pin port.
// Assumes the bench sets what the outside world drives when the port does not.
module gp_pad_model (
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_drv,
  output logic [7:0]      o_pad
);
  timeunit 1ns;
  timeprecision 100ps;
  // Outside source holds its level steady until the bench changes it
  assign o_pad = (i_oe & i_out) | (~i_oe & i_drv);
endmodule // gp_pad_model

// ==== dv/tb.sv ====
// Self-checking bench for the port configured as port B (debug bit 7, trigger bit 4).
// Assumes the pad model stands in for the pins; peripheral lines come from here.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import gp_pkg::*;
  logic i_clk = 0, i_rstn = 0, i_data_wr = 0, i_data_rd = 0, i_cfg_wr = 0, i_cfg_rd = 0;
  logic [7:0] i_alt_out = 0, i_alt_oe = 0, i_data_wdata = 0, drv = 0, pin;
  logic [9:0] i_data_addr = 0;
  logic [31:0] i_cfg_wdata = 0;
  logic [3:0] i_id_index = 0;
  gp_cfg_t i_cfg_sel = GP_CFG_DIR;
  logic [7:0] o_pin_out, o_pin_oe, o_data_rdata, o_alt_function_select, o_commit_enable, o_pull_up_enable;
  logic [7:0] o_pull_down_enable, o_digital_input_enable, o_irq_raw_status, o_irq_masked_status;
  logic [7:0] o_cfg_rdata, o_id_byte, o_pin_direction, o_alt_in, o_drive_low_select, o_drive_mid_select;
  logic [7:0] o_drive_high_select, o_open_drain_enable, o_slew_rate_enable;
  logic o_irq, o_converter_trigger, o_commit_unlocked;
  int fails = 0, n_compared = 0, tc = 0;
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_converter_trigger === 1'b1) tc++;
  gp_pad_model u_gp_pad_model (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_drv(drv), .o_pad(pin));
  gp_port #(.PROT_MASK(GP_PROT_PORT_B), .TRIG_EN(1'b1)) u_gp_port (.i_clk, .i_rstn, .i_pin_in(pin),
    .o_pin_out, .o_pin_oe, .i_alt_out, .i_alt_oe, .o_alt_in, .i_data_wr, .i_data_rd, .i_data_addr,
    .i_data_wdata, .o_data_rdata, .i_cfg_wr, .i_cfg_rd, .i_cfg_sel, .i_cfg_wdata, .o_cfg_rdata,
    .i_id_index, .o_id_byte, .o_pin_direction, .o_alt_function_select, .o_commit_enable,
    .o_commit_unlocked, .o_drive_low_select, .o_drive_mid_select, .o_drive_high_select,
    .o_open_drain_enable, .o_pull_up_enable, .o_pull_down_enable, .o_slew_rate_enable,
    .o_digital_input_enable, .o_irq_raw_status, .o_irq_masked_status, .o_irq, .o_converter_trigger);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Extra cycle after each config write keeps checks clear of the update edge
  task automatic cw(input gp_cfg_t s, input logic [31:0] d);
    i_cfg_sel = s;
    i_cfg_wdata = d;
    i_cfg_wr = 1;
    tick(1);
    i_cfg_wr = 0;
    tick(1);
  endtask
  task automatic dw(input logic [9:0] a, input logic [7:0] d);
    i_data_addr = a;
    i_data_wdata = d;
    i_data_wr = 1;
    tick(1);
    i_data_wr = 0;
  endtask
  task automatic dr(input logic [9:0] a, input logic [7:0] e);
    i_data_addr = a;
    i_data_rd = 1;
    tick(1);
    i_data_rd = 0;
    tick(1);
    chk("rdata", o_data_rdata, e);
  endtask
  // Read strobe drops for a cycle so back-to-back reads never retoggle it
  task automatic cr(input gp_cfg_t s);
    i_cfg_sel = s;
    i_cfg_rd = 1;
    tick(1);
    i_cfg_rd = 0;
    tick(1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    i_rstn = 0;
    tick(3);
    i_rstn = 1;
    chk("afsel", o_alt_function_select, 8'h80);
    chk("den", o_digital_input_enable, 8'h80);
    chk("pur", o_pull_up_enable, 8'h80);
    chk("pdr", o_pull_down_enable, 8'h00);
    chk("commit", o_commit_enable, 8'h7F);
    tick(3);
    $display("Test reset done");
  endtask
  task automatic t_data();
    cw(GP_CFG_DEN, 32'h0000_00FF);
    cw(GP_CFG_DIR, 32'h0000_00FF);
    chk("dir", o_pin_direction, 8'hFF);
    dw(10'h098, 8'hEB);
    dr(10'h3FC, 8'h22);
    dr(10'h0C4, 8'h20);
    tick(1);
    chk("pin_out", o_pin_out & o_pin_oe, 8'h22);
    $display("Test data done");
  endtask
  task automatic t_irq();
    cw(GP_CFG_IEV, 32'h0000_00FF);
    cw(GP_CFG_IM, 32'h0000_0010);
    cw(GP_CFG_DIR, 32'h0000_0000);
    tick(4);
    tc = 0;
    drv = 8'h10;
    tick(6);
    dr(10'h3FC, 8'h10);
    drv = 8'h00;
    tick(4);
    chk("raw", o_irq_raw_status, 8'h10);
    chk("mis", o_irq_masked_status, 8'h10);
    chk("irq", {7'h00, o_irq}, 8'h01);
    chk("trig", tc[7:0], 8'h01);
    cw(GP_CFG_ICR, 32'h0000_0000);
    chk("raw", o_irq_raw_status, 8'h10);
    cw(GP_CFG_ICR, 32'h0000_0010);
    chk("raw", o_irq_raw_status, 8'h00);
    chk("irq", {7'h00, o_irq}, 8'h00);
    $display("Test irq done");
  endtask
  task automatic t_commit();
    cw(GP_CFG_AFSEL, 32'h0000_0001);
    chk("afsel", o_alt_function_select, 8'h81);
    cw(GP_CFG_CR, 32'h0000_00FF);
    chk("commit", o_commit_enable, 8'h7F);
    cw(GP_CFG_LOCK, GP_LOCK_KEY);
    chk("unlocked", {7'h00, o_commit_unlocked}, 8'h01);
    cw(GP_CFG_CR, 32'h0000_00FF);
    cw(GP_CFG_AFSEL, 32'h0000_0001);
    chk("afsel", o_alt_function_select, 8'h01);
    i_alt_out = 8'h01;
    i_alt_oe = 8'h01;
    tick(3);
    chk("alt_pin", {6'h00, o_pin_oe[0], o_pin_out[0]}, 8'h03);
    chk("alt_in", o_alt_in, 8'h01);
    $display("Test commit done");
  endtask
  task automatic t_pad();
    cw(GP_CFG_DR4, 32'h0000_000F);
    cw(GP_CFG_SLR, 32'h0000_0003);
    cw(GP_CFG_ODR, 32'h0000_0002);
    chk("dr2", o_drive_low_select, 8'hFF);
    chk("dr4", o_drive_mid_select, 8'h0F);
    chk("dr8", o_drive_high_select, 8'h00);
    chk("slr", o_slew_rate_enable, 8'h03);
    chk("odr", o_open_drain_enable, 8'h02);
    cr(GP_CFG_RIS);
    chk("ris", o_cfg_rdata, 8'h01);
    cr(GP_CFG_MIS);
    chk("mis", o_cfg_rdata, 8'h00);
    cw(GP_CFG_LOCK, 32'h0000_0000);
    cr(GP_CFG_LOCK);
    chk("lock", o_cfg_rdata, 8'h01);
    i_id_index = 4'h4;
    tick(2);
    chk("id", o_id_byte, GP_ID_BYTES[4]);
    i_id_index = 4'hC;
    tick(2);
    chk("id_none", o_id_byte, 8'h00);
    $display("Test pad done");
  endtask
  task automatic end_sim();
    $display("Compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    end_sim();
  end
  initial begin
    @(posedge i_clk);
    #1;
    t_reset();
    t_data();
    t_irq();
    t_commit();
    t_pad();
    t_reset();
    end_sim();
  end
endmodule // tb

// ==== rtl/gp_irq_pin.sv ====
// One pin's interrupt detector: trigger select and raw status.
// Assumes a level already synchronised to i_clk.
module gp_irq_pin
  import gp_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_level,
  input  wire logic i_sense,
  input  wire logic i_both,
  input  wire logic i_event,
  input  wire logic i_clear,
  output logic      o_raw
);

  logic prev_reg;
  logic prev_next;
  logic raw_reg;
  logic raw_next;
  logic rise;
  logic fall;
  logic edge_hit;

  // ----------------------------------------------------------------
  // Trigger decode
  // ----------------------------------------------------------------
  always_comb begin
    rise      = i_level & ~prev_reg;
    fall      = ~i_level & prev_reg;
    edge_hit  = i_both ? (rise | fall) : (i_event ? rise : fall);
    prev_next = i_level;
    if (i_sense) begin
      raw_next = (i_level == i_event);
    end else if (edge_hit) begin
      raw_next = 1'b1;
    end else if (i_clear) begin
      raw_next = 1'b0;
    end else begin
      raw_next = raw_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      prev_reg <= 1'b0;
      raw_reg  <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      raw_reg  <= raw_next;
    end
  end

  assign o_raw = raw_reg;

endmodule // gp_irq_pin

// ==== rtl/gp_pkg.sv ====
// Shared constants, types and identity values for the eight-pin port.
// Assumes one system clock and a synchronous active-low reset.
package gp_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int unsigned GP_NPINS      = 8;
  localparam int unsigned GP_ADDR_W     = 10;
  localparam int unsigned GP_MASK_LSB   = 2;
  localparam int unsigned GP_ID_COUNT   = 12;

  // ----------------------------------------------------------------
  // Reset values, ordinary pins
  // ----------------------------------------------------------------
  localparam logic [7:0] GP_AFSEL_RST   = 8'h00;
  localparam logic [7:0] GP_DEN_RST     = 8'h00;
  localparam logic [7:0] GP_PUR_RST     = 8'h00;
  localparam logic [7:0] GP_PDR_RST     = 8'h00;
  localparam logic [7:0] GP_DR2_RST     = 8'hFF;
  localparam logic [7:0] GP_ZERO8       = 8'h00;
  localparam logic [7:0] GP_ONES8       = 8'hFF;

  // ----------------------------------------------------------------
  // Debug-pin masks per port, trigger bit and commit lock key
  // ----------------------------------------------------------------
  localparam logic [7:0]  GP_PROT_PORT_B = 8'h80;
  localparam logic [7:0]  GP_PROT_PORT_C = 8'h0F;
  localparam logic [7:0]  GP_PROT_NONE   = 8'h00;
  localparam int unsigned GP_TRIG_BIT    = 4;
  // Lock key value is arbitrary
  localparam logic [31:0] GP_LOCK_KEY    = 32'h0000_5A5A;

  // ----------------------------------------------------------------
  // Configuration select codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    GP_CFG_DIR   = 5'h00,
    GP_CFG_IS    = 5'h01,
    GP_CFG_IBE   = 5'h02,
    GP_CFG_IEV   = 5'h03,
    GP_CFG_IM    = 5'h04,
    GP_CFG_RIS   = 5'h05,
    GP_CFG_MIS   = 5'h06,
    GP_CFG_ICR   = 5'h07,
    GP_CFG_AFSEL = 5'h08,
    GP_CFG_DR2   = 5'h09,
    GP_CFG_DR4   = 5'h0A,
    GP_CFG_DR8   = 5'h0B,
    GP_CFG_ODR   = 5'h0C,
    GP_CFG_PUR   = 5'h0D,
    GP_CFG_PDR   = 5'h0E,
    GP_CFG_SLR   = 5'h0F,
    GP_CFG_DEN   = 5'h10,
    GP_CFG_LOCK  = 5'h11,
    GP_CFG_CR    = 5'h12
  } gp_cfg_t;

  typedef enum logic {
    GP_LOCKED   = 1'b0,
    GP_UNLOCKED = 1'b1
  } gp_lock_t;

  // Identity bytes: values are arbitrary
  localparam logic [7:0] GP_ID_BYTES [0:GP_ID_COUNT-1] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22,
    8'h33, 8'h01, 8'h0D, 8'hF0, 8'h05, 8'hB1
  };

endpackage

// ==== rtl/gp_port.sv ====
// Eight-pin general-purpose port: data window, interrupts, mode, commit, pads.
// Assumes pins and strobes are synchronous to i_clk; one reset covers
// both power-on and the reset pin.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module gp_port
  import gp_pkg::*;
#(
  parameter logic [7:0]  PAD_MASK  = 8'hFF,
  parameter logic [7:0]  PROT_MASK = GP_PROT_NONE,
  parameter bit          TRIG_EN   = 1'b0
)(
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic [7:0]           i_pin_in,
  output logic [7:0]                o_pin_out,
  output logic [7:0]                o_pin_oe,
  input  wire logic [7:0]           i_alt_out,
  input  wire logic [7:0]           i_alt_oe,
  output logic [7:0]                o_alt_in,
  input  wire logic                 i_data_wr,
  input  wire logic                 i_data_rd,
  input  wire logic [GP_ADDR_W-1:0] i_data_addr,
  input  wire logic [7:0]           i_data_wdata,
  output logic [7:0]                o_data_rdata,
  input  wire logic                 i_cfg_wr,
  input  wire logic                 i_cfg_rd,
  input  wire gp_cfg_t              i_cfg_sel,
  input  wire logic [31:0]          i_cfg_wdata,
  output logic [7:0]                o_cfg_rdata,
  input  wire logic [3:0]           i_id_index,
  output logic [7:0]                o_id_byte,
  output logic [7:0]                o_pin_direction,
  output logic [7:0]                o_alt_function_select,
  output logic [7:0]                o_commit_enable,
  output logic                      o_commit_unlocked,
  output logic [7:0]                o_drive_low_select,
  output logic [7:0]                o_drive_mid_select,
  output logic [7:0]                o_drive_high_select,
  output logic [7:0]                o_open_drain_enable,
  output logic [7:0]                o_pull_up_enable,
  output logic [7:0]                o_pull_down_enable,
  output logic [7:0]                o_slew_rate_enable,
  output logic [7:0]                o_digital_input_enable,
  output logic [7:0]                o_irq_raw_status,
  output logic [7:0]                o_irq_masked_status,
  output logic                      o_irq,
  output logic                      o_converter_trigger
);

  if ((PROT_MASK & ~PAD_MASK) != GP_ZERO8) begin : g_chk
    $error("Protected bits must have pads");
  end

  localparam logic [7:0] AFSEL_INIT = (GP_AFSEL_RST | PROT_MASK) & PAD_MASK;
  localparam logic [7:0] DEN_INIT   = (GP_DEN_RST | PROT_MASK) & PAD_MASK;
  localparam logic [7:0] PUR_INIT   = (GP_PUR_RST | PROT_MASK) & PAD_MASK;
  localparam logic [7:0] PDR_INIT   = GP_PDR_RST;
  localparam logic [7:0] DR2_INIT   = GP_DR2_RST & PAD_MASK;
  localparam logic [7:0] CR_INIT    = GP_ONES8 & ~PROT_MASK;

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sync1_reg <= GP_ZERO8;
      sync2_reg <= GP_ZERO8;
    end else begin
      sync1_reg <= i_pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] dir_reg,   dir_next;
  logic [7:0] is_reg,    is_next;
  logic [7:0] ibe_reg,   ibe_next;
  logic [7:0] iev_reg,   iev_next;
  logic [7:0] im_reg,    im_next;
  logic [7:0] afsel_reg, afsel_next;
  logic [7:0] dr2_reg,   dr2_next;
  logic [7:0] dr4_reg,   dr4_next;
  logic [7:0] dr8_reg,   dr8_next;
  logic [7:0] odr_reg,   odr_next;
  logic [7:0] pur_reg,   pur_next;
  logic [7:0] pdr_reg,   pdr_next;
  logic [7:0] slr_reg,   slr_next;
  logic [7:0] den_reg,   den_next;
  logic [7:0] cr_reg,    cr_next;
  gp_lock_t   lock_reg,  lock_next;
  logic [7:0] wr_val;
  logic [7:0] icr_pulse;
  logic [7:0] afsel_open;

  // Unconnected bits keep their reset value
  function automatic logic [7:0] pad_wr(input logic [7:0] old_v, input logic [7:0] new_v);
    pad_wr = (old_v & ~PAD_MASK) | (new_v & PAD_MASK);
  endfunction

  always_comb begin
    wr_val     = i_cfg_wdata[7:0];
    dir_next   = dir_reg;
    is_next    = is_reg;
    ibe_next   = ibe_reg;
    iev_next   = iev_reg;
    im_next    = im_reg;
    afsel_next = afsel_reg;
    dr2_next   = dr2_reg;
    dr4_next   = dr4_reg;
    dr8_next   = dr8_reg;
    odr_next   = odr_reg;
    pur_next   = pur_reg;
    pdr_next   = pdr_reg;
    slr_next   = slr_reg;
    den_next   = den_reg;
    cr_next    = cr_reg;
    lock_next  = lock_reg;
    icr_pulse  = GP_ZERO8;
    // Protected bits open only while unlocked and committed
    afsel_open = ~PROT_MASK | ((lock_reg == GP_UNLOCKED) ? cr_reg : GP_ZERO8);
    if (i_cfg_wr) begin
      case (i_cfg_sel)
        GP_CFG_DIR:   dir_next = pad_wr(dir_reg, wr_val);
        GP_CFG_IS:    is_next  = pad_wr(is_reg, wr_val);
        GP_CFG_IBE:   ibe_next = pad_wr(ibe_reg, wr_val);
        GP_CFG_IEV:   iev_next = pad_wr(iev_reg, wr_val);
        GP_CFG_IM:    im_next  = pad_wr(im_reg, wr_val);
        GP_CFG_ICR:   icr_pulse = wr_val & PAD_MASK;
        GP_CFG_AFSEL: afsel_next = pad_wr(afsel_reg, (afsel_reg & ~afsel_open) | (wr_val & afsel_open));
        GP_CFG_DR2:   dr2_next = pad_wr(dr2_reg, wr_val);
        GP_CFG_DR4:   dr4_next = pad_wr(dr4_reg, wr_val);
        GP_CFG_DR8:   dr8_next = pad_wr(dr8_reg, wr_val);
        GP_CFG_ODR:   odr_next = pad_wr(odr_reg, wr_val);
        GP_CFG_PUR:   pur_next = pad_wr(pur_reg, wr_val);
        GP_CFG_PDR:   pdr_next = pad_wr(pdr_reg, wr_val);
        GP_CFG_SLR:   slr_next = pad_wr(slr_reg, wr_val);
        GP_CFG_DEN:   den_next = pad_wr(den_reg, wr_val);
        GP_CFG_LOCK:  lock_next = (i_cfg_wdata == GP_LOCK_KEY) ? GP_UNLOCKED : GP_LOCKED;
        GP_CFG_CR: begin
          if (lock_reg == GP_UNLOCKED) begin
            cr_next = (cr_reg & ~PROT_MASK) | (wr_val & PROT_MASK);
          end
        end
        default: ;
      endcase
    end
  end

  // Sync reset covers power-on and pin reset alike
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      dir_reg   <= GP_ZERO8;
      is_reg    <= GP_ZERO8;
      ibe_reg   <= GP_ZERO8;
      iev_reg   <= GP_ZERO8;
      im_reg    <= GP_ZERO8;
      afsel_reg <= AFSEL_INIT;
      dr2_reg   <= DR2_INIT;
      dr4_reg   <= GP_ZERO8;
      dr8_reg   <= GP_ZERO8;
      odr_reg   <= GP_ZERO8;
      pur_reg   <= PUR_INIT;
      pdr_reg   <= PDR_INIT;
      slr_reg   <= GP_ZERO8;
      den_reg   <= DEN_INIT;
      cr_reg    <= CR_INIT;
      lock_reg  <= GP_LOCKED;
    end else begin
      dir_reg   <= dir_next;
      is_reg    <= is_next;
      ibe_reg   <= ibe_next;
      iev_reg   <= iev_next;
      im_reg    <= im_next;
      afsel_reg <= afsel_next;
      dr2_reg   <= dr2_next;
      dr4_reg   <= dr4_next;
      dr8_reg   <= dr8_next;
      odr_reg   <= odr_next;
      pur_reg   <= pur_next;
      pdr_reg   <= pdr_next;
      slr_reg   <= slr_next;
      den_reg   <= den_next;
      cr_reg    <= cr_next;
      lock_reg  <= lock_next;
    end
  end

  // ----------------------------------------------------------------
  // Data register and masked window
  // ----------------------------------------------------------------
  logic [7:0] data_reg,  data_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] addr_mask;
  logic [7:0] wr_mask;

  always_comb begin
    addr_mask  = i_data_addr[GP_ADDR_W-1:GP_MASK_LSB];
    wr_mask    = i_data_wr ? (addr_mask & PAD_MASK) : GP_ZERO8;
    data_next  = (data_reg & ~wr_mask) | (i_data_wdata & wr_mask);
    // Input bits follow the pin where den_reg is set, else read zero; a write to them is overwritten
    data_next  = (data_next & dir_reg) | (sync2_reg & den_reg & ~dir_reg & PAD_MASK);
    rdata_next = i_data_rd ? (data_reg & addr_mask) : rdata_reg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      data_reg  <= GP_ZERO8;
      rdata_reg <= GP_ZERO8;
    end else begin
      data_reg  <= data_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt detectors
  // ----------------------------------------------------------------
  logic [7:0] raw;
  logic [7:0] masked;

  for (genvar g = 0; g < GP_NPINS; g++) begin : g_irq
    gp_irq_pin u_irq (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_level (sync2_reg[g] & PAD_MASK[g]),
      .i_sense (is_reg[g]),
      .i_both  (ibe_reg[g]),
      .i_event (iev_reg[g]),
      .i_clear (icr_pulse[g]),
      .o_raw   (raw[g])
    );
  end

  assign masked = raw & im_reg;

  logic trig_reg, trig_next;
  logic trig_src_reg, trig_src_next;

  // Pulse when the trigger bit's masked status rises, not on the held status
  always_comb begin
    trig_src_next = TRIG_EN & masked[GP_TRIG_BIT];
    trig_next     = trig_src_next & ~trig_src_reg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      trig_reg     <= 1'b0;
      trig_src_reg <= 1'b0;
    end else begin
      trig_reg     <= trig_next;
      trig_src_reg <= trig_src_next;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, readback and identity
  // ----------------------------------------------------------------
  logic [7:0] out_reg,  out_next;
  logic [7:0] oe_reg,   oe_next;
  logic [7:0] crd_reg,  crd_next;
  logic [7:0] id_reg,   id_next;
  logic [7:0] src_out;
  logic [7:0] src_oe;

  always_comb begin
    src_out  = (afsel_reg & i_alt_out) | (~afsel_reg & data_reg);
    src_oe   = (afsel_reg & i_alt_oe) | (~afsel_reg & dir_reg);
    // Open drain only ever pulls low
    out_next = src_out & ~odr_reg & PAD_MASK;
    oe_next  = src_oe & ~(odr_reg & src_out) & PAD_MASK;
    crd_next = crd_reg;
    if (i_cfg_rd) begin
      case (i_cfg_sel)
        GP_CFG_DIR:   crd_next = dir_reg;
        GP_CFG_IS:    crd_next = is_reg;
        GP_CFG_IBE:   crd_next = ibe_reg;
        GP_CFG_IEV:   crd_next = iev_reg;
        GP_CFG_IM:    crd_next = im_reg;
        GP_CFG_RIS:   crd_next = raw;
        GP_CFG_MIS:   crd_next = masked;
        GP_CFG_AFSEL: crd_next = afsel_reg;
        GP_CFG_DR2:   crd_next = dr2_reg;
        GP_CFG_DR4:   crd_next = dr4_reg;
        GP_CFG_DR8:   crd_next = dr8_reg;
        GP_CFG_ODR:   crd_next = odr_reg;
        GP_CFG_PUR:   crd_next = pur_reg;
        GP_CFG_PDR:   crd_next = pdr_reg;
        GP_CFG_SLR:   crd_next = slr_reg;
        GP_CFG_DEN:   crd_next = den_reg;
        GP_CFG_LOCK:  crd_next = {7'h00, lock_reg == GP_LOCKED};
        GP_CFG_CR:    crd_next = cr_reg;
        default:      crd_next = GP_ZERO8;
      endcase
    end
    id_next = (i_id_index < 4'(GP_ID_COUNT)) ? GP_ID_BYTES[i_id_index] : GP_ZERO8;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      out_reg <= GP_ZERO8;
      oe_reg  <= GP_ZERO8;
      crd_reg <= GP_ZERO8;
      id_reg  <= GP_ZERO8;
    end else begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
      crd_reg <= crd_next;
      id_reg  <= id_next;
    end
  end

  assign o_pin_out              = out_reg;
  assign o_pin_oe               = oe_reg;
  assign o_alt_in               = sync2_reg & den_reg & PAD_MASK;
  assign o_data_rdata           = rdata_reg;
  assign o_cfg_rdata            = crd_reg;
  assign o_id_byte              = id_reg;
  assign o_pin_direction        = dir_reg;
  assign o_alt_function_select  = afsel_reg;
  assign o_commit_enable        = cr_reg;
  assign o_commit_unlocked      = (lock_reg == GP_UNLOCKED);
  assign o_drive_low_select     = dr2_reg;
  assign o_drive_mid_select     = dr4_reg;
  assign o_drive_high_select    = dr8_reg;
  assign o_open_drain_enable    = odr_reg;
  assign o_pull_up_enable       = pur_reg;
  assign o_pull_down_enable     = pdr_reg;
  assign o_slew_rate_enable     = slr_reg;
  assign o_digital_input_enable = den_reg;
  assign o_irq_raw_status       = raw;
  assign o_irq_masked_status    = masked;
  assign o_irq                  = |masked;
  assign o_converter_trigger    = trig_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_reset_plain: assert property ($rose(i_rstn) |-> ((afsel_reg | den_reg | pur_reg | pdr_reg) & ~PROT_MASK) == 8'h00)
    else $error("Ordinary pin not undriven after reset");
  a_reset_debug: assert property ($rose(i_rstn) |-> (afsel_reg & den_reg & pur_reg & PROT_MASK) == PROT_MASK)
    else $error("Debug pin not in debug function after reset");
  a_reset_commit: assert property ($rose(i_rstn) |-> cr_reg == (8'hFF & ~PROT_MASK))
    else $error("Commit bits wrong after reset");
  a_data_keep: assert property (i_data_wr && $stable(dir_reg) |=>
    ((data_reg ^ $past(data_reg)) & ~$past(addr_mask) & $past(dir_reg)) == 8'h00)
    else $error("Unmasked data bit changed on write");
  a_data_set: assert property (i_data_wr ##1 $stable(dir_reg) |-> ((data_reg ^ $past(i_data_wdata)) & $past(addr_mask) & dir_reg & PAD_MASK) == 8'h00)
    else $error("Masked data bit not written");
  a_read_zero: assert property (i_data_rd |=> (o_data_rdata & ~$past(addr_mask)) == 8'h00)
    else $error("Unmasked read bit not zero");
  a_irq_or: assert property (o_irq == (|(o_irq_raw_status & o_irq_masked_status & im_reg)))
    else $error("Port interrupt disagrees with masked status");
  a_edge_held: assert property (raw[0] && !is_reg[0] && !icr_pulse[0] ##1 !is_reg[0] |-> raw[0])
    else $error("Edge interrupt dropped without clear");
  a_clear_ack: assert property (icr_pulse[GP_TRIG_BIT] && !is_reg[GP_TRIG_BIT] && !ibe_reg[GP_TRIG_BIT]
    && iev_reg[GP_TRIG_BIT] && !sync2_reg[GP_TRIG_BIT] ##1 !is_reg[GP_TRIG_BIT] |-> !raw[GP_TRIG_BIT])
    else $error("Write-one clear ignored");
  a_trig_one: assert property (o_converter_trigger |=> !o_converter_trigger)
    else $error("Converter trigger longer than one cycle");
  a_trig_cause: assert property (o_converter_trigger |-> $past(im_reg[GP_TRIG_BIT], 1) || im_reg[GP_TRIG_BIT])
    else $error("Converter trigger while bit masked");
  a_commit_guard: assert property (((afsel_reg ^ $past(afsel_reg)) & PROT_MASK) != 8'h00 |-> $past(lock_reg == GP_UNLOCKED) && ((afsel_reg ^ $past(afsel_reg)) & ~$past(cr_reg)) == 8'h00)
    else $error("Protected select changed without commit");
  a_alt_drive: assert property (odr_reg == 8'h00 |=>
    ((o_pin_oe ^ $past(i_alt_oe)) & $past(afsel_reg) & PAD_MASK) == 8'h00)
    else $error("Alternate function not driving pin enable");

  c_data_write: cover property (i_data_wr && addr_mask != 8'h00 && addr_mask != 8'hFF);
  c_irq_edge:   cover property (!o_irq ##1 o_irq);
  c_trig:       cover property (o_converter_trigger);
  c_unlock:     cover property (lock_reg == GP_UNLOCKED && i_cfg_wr && i_cfg_sel == GP_CFG_AFSEL);

endmodule // gp_port
